// ### core/psc_regs.sv
// Purpose: Complement-protected output, oscillator frequency and supervisor controls
// Assumes: Single clock, strobe register port, read data one cycle later
// Notes: Refresh and error events arrive from the supervisor timer
//
// What this block does
// - Output complement bits at 2,1,0
// - Applied zero drives low, one releases
// - Modulation rate bit 5 selects 23.5/94 kHz
// - Bit 4 enables frequency spreading
// - Frequency codes map to 16-24 MHz
// - Frequency applied only with matching complement
// - Complement register holds frequency copy
// - Error limit 8/6/4/2 when copies match
// - Refresh limit 6/4/2/1 when copies match
// - Fail action: stay, init, or deep failsafe
// - Fail action applied only when copies match
// - Three-bit refresh counter wraps to zero
// - Four-bit error counter readable at 3:0
// - All fields reset on power-on
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
module psc_regs (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [psc_pkg::AW-1:0] addr_i,
    input wire logic [psc_pkg::DW-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [psc_pkg::DW-1:0] rdata_o,
    // Supervisor events
    input wire logic refresh_ok_i,
    input wire logic refresh_bad_i,
    // Output pins, open-drain style
    output logic [2:0] out_pin_o,
    output logic [2:0] out_pin_oe_o,
    // Oscillator controls
    output logic [3:0] osc_freq_sel_o,
    output logic spread_enable_o,
    output logic spread_mod_rate_o,
    output logic [6:0] osc_mhz_o,
    // Supervisor outcome
    output logic sup_fail_o,
    output logic go_init_o,
    output logic deep_failsafe_state_o
);
    typedef struct packed {
        // Fields written over the register port
        logic [2:0] out_ctrl;
        logic [2:0] out_ctrl_inv;
        logic spread_mod_rate;
        logic spread_enable;
        logic [3:0] osc_freq_sel;
        logic [3:0] osc_freq_sel_inv;
        logic [1:0] err_lim;
        logic [1:0] rfr_lim;
        logic [1:0] fail_act;
        logic [1:0] err_lim_inv;
        logic [1:0] rfr_lim_inv;
        logic [1:0] fail_act_inv;
        // Watchdog counters
        logic [2:0] rfr_cnt;
        logic [3:0] err_cnt;
        // Read answer and registered outputs
        logic [15:0] rdata;
        logic [2:0] pin;
        logic [2:0] pin_oe;
        logic [3:0] freq_o;
        logic [6:0] mhz;
        logic fail;
        logic go_init;
        logic deep;
    } psc_state_s;

    psc_state_s r, nxt;
    logic [2:0] out_app;
    logic [3:0] freq_app;
    logic [1:0] err_app, rfr_app, fail_app;

    // ---------------------------------------------
    // Protected fields
    // ---------------------------------------------
    psc_match #(.W(3), .RST(~psc_pkg::OUT_RST)) u_out (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .true_i(r.out_ctrl),
        .inv_i(r.out_ctrl_inv),
        .applied_o(out_app)
    );
    psc_match #(.W(4), .RST(psc_pkg::FREQ_RST)) u_freq (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .true_i(r.osc_freq_sel),
        .inv_i(r.osc_freq_sel_inv),
        .applied_o(freq_app)
    );
    psc_match #(.W(2), .RST(psc_pkg::LIM_RST)) u_err (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .true_i(r.err_lim),
        .inv_i(r.err_lim_inv),
        .applied_o(err_app)
    );
    psc_match #(.W(2), .RST(psc_pkg::LIM_RST)) u_rfr (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .true_i(r.rfr_lim),
        .inv_i(r.rfr_lim_inv),
        .applied_o(rfr_app)
    );
    psc_match #(.W(2), .RST(psc_pkg::FAIL_STAY)) u_fail (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .true_i(r.fail_act),
        .inv_i(r.fail_act_inv),
        .applied_o(fail_app)
    );

    // ---------------------------------------------
    // Decoders
    // ---------------------------------------------
    // Limit codes count down from the loosest setting
    function automatic logic [3:0] err_max(input logic [1:0] c);
        case (c)
            2'h0: err_max = psc_pkg::ERR_MAX_00;
            2'h1: err_max = psc_pkg::ERR_MAX_01;
            2'h2: err_max = psc_pkg::ERR_MAX_10;
            default: err_max = psc_pkg::ERR_MAX_11;
        endcase
    endfunction

    function automatic logic [2:0] rfr_max(input logic [1:0] c);
        case (c)
            2'h0: rfr_max = psc_pkg::RFR_MAX_00;
            2'h1: rfr_max = psc_pkg::RFR_MAX_01;
            2'h2: rfr_max = psc_pkg::RFR_MAX_10;
            default: rfr_max = psc_pkg::RFR_MAX_11;
        endcase
    endfunction

    // Zero means a code with no defined frequency
    function automatic logic [6:0] freq_mhz(input logic [3:0] c);
        case (c)
            4'h0: freq_mhz = 7'h14;
            4'h1: freq_mhz = 7'h15;
            4'h2: freq_mhz = 7'h16;
            4'h3: freq_mhz = 7'h17;
            4'h4: freq_mhz = 7'h18;
            4'h9: freq_mhz = 7'h10;
            4'hA: freq_mhz = 7'h11;
            4'hB: freq_mhz = 7'h12;
            default: freq_mhz = 7'h00;
        endcase
    endfunction

    function automatic logic [15:0] pack_sup(
        input psc_state_s s,
        input logic inv
    );
        pack_sup = '0;
        if (inv) begin
            pack_sup[psc_pkg::ERR_LIM_LSB +: 2] = s.err_lim_inv;
            pack_sup[psc_pkg::RFR_LIM_LSB +: 2] = s.rfr_lim_inv;
            pack_sup[psc_pkg::FAIL_LSB +: 2] = s.fail_act_inv;
        end else begin
            pack_sup[psc_pkg::ERR_LIM_LSB +: 2] = s.err_lim;
            pack_sup[psc_pkg::RFR_LIM_LSB +: 2] = s.rfr_lim;
            pack_sup[psc_pkg::FAIL_LSB +: 2] = s.fail_act;
            pack_sup[psc_pkg::RFR_CNT_LSB +: 3] = s.rfr_cnt;
            pack_sup[psc_pkg::ERR_CNT_LSB +: 4] = s.err_cnt;
        end
    endfunction

    // ---------------------------------------------
    // Next state
    // ---------------------------------------------
    always_comb begin
        logic fail_now;
        fail_now = 1'b0;
        nxt = r;
        nxt.fail = 1'b0;
        nxt.rdata = '0;
        // A bad refresh wins over a good one in one cycle
        // Supervisor counters
        if (refresh_bad_i) begin
            if (r.err_cnt + 4'h2 >= err_max(err_app)) begin
                fail_now = 1'b1;
                nxt.err_cnt = '0;
            end else begin
                nxt.err_cnt = r.err_cnt + 4'h2;
            end
            nxt.rfr_cnt = '0;
        end else if (refresh_ok_i) begin
            if (r.rfr_cnt + 3'h1 >= rfr_max(rfr_app)) begin
                nxt.rfr_cnt = '0;
                if (r.err_cnt != '0) begin
                    nxt.err_cnt = r.err_cnt - 4'h1;
                end
            end else begin
                nxt.rfr_cnt = r.rfr_cnt + 3'h1;
            end
        end
        // Fail action only ever sets; reset alone clears it
        if (fail_now) begin
            nxt.fail = 1'b1;
            case (fail_app)
                psc_pkg::FAIL_INIT: nxt.go_init = 1'b1;
                psc_pkg::FAIL_DEEP: nxt.deep = 1'b1;
                default: nxt.go_init = r.go_init;
            endcase
        end
        // Register writes
        // Unmapped indices leave every field untouched
        if (wr_i) begin
            case (addr_i)
                psc_pkg::ADDR_OUT_CTRL:
                    nxt.out_ctrl = wdata_i[psc_pkg::OUT_LSB +: 3];
                psc_pkg::ADDR_OUT_INV:
                    nxt.out_ctrl_inv = wdata_i[psc_pkg::OUT_LSB +: 3];
                psc_pkg::ADDR_OSC: begin
                    nxt.spread_mod_rate = wdata_i[psc_pkg::MOD_RATE_BIT];
                    nxt.spread_enable = wdata_i[psc_pkg::SPREAD_EN_BIT];
                    nxt.osc_freq_sel = wdata_i[psc_pkg::FREQ_LSB +: 4];
                end
                psc_pkg::ADDR_OSC_INV:
                    nxt.osc_freq_sel_inv = wdata_i[psc_pkg::FREQ_LSB +: 4];
                psc_pkg::ADDR_SUP1: begin
                    nxt.err_lim = wdata_i[psc_pkg::ERR_LIM_LSB +: 2];
                    nxt.rfr_lim = wdata_i[psc_pkg::RFR_LIM_LSB +: 2];
                    nxt.fail_act = wdata_i[psc_pkg::FAIL_LSB +: 2];
                end
                psc_pkg::ADDR_SUP1_INV: begin
                    nxt.err_lim_inv = wdata_i[psc_pkg::ERR_LIM_LSB +: 2];
                    nxt.rfr_lim_inv = wdata_i[psc_pkg::RFR_LIM_LSB +: 2];
                    nxt.fail_act_inv = wdata_i[psc_pkg::FAIL_LSB +: 2];
                end
                default: nxt.rfr_cnt = nxt.rfr_cnt;
            endcase
        end
        // Register reads, answered the next cycle
        // Outside the answer cycle the read data stay zero
        if (rd_i) begin
            case (addr_i)
                psc_pkg::ADDR_OUT_CTRL:
                    nxt.rdata[psc_pkg::OUT_LSB +: 3] = r.out_ctrl;
                psc_pkg::ADDR_OUT_INV:
                    nxt.rdata[psc_pkg::OUT_LSB +: 3] = r.out_ctrl_inv;
                psc_pkg::ADDR_OSC: begin
                    nxt.rdata[psc_pkg::MOD_RATE_BIT] = r.spread_mod_rate;
                    nxt.rdata[psc_pkg::SPREAD_EN_BIT] = r.spread_enable;
                    nxt.rdata[psc_pkg::FREQ_LSB +: 4] = r.osc_freq_sel;
                end
                psc_pkg::ADDR_OSC_INV:
                    nxt.rdata[psc_pkg::FREQ_LSB +: 4] = r.osc_freq_sel_inv;
                psc_pkg::ADDR_SUP1: nxt.rdata = pack_sup(r, 1'b0);
                psc_pkg::ADDR_SUP1_INV: nxt.rdata = pack_sup(r, 1'b1);
                psc_pkg::ADDR_SUP_EVT: begin
                    nxt.rdata[psc_pkg::EVT_REFRESH_BIT] = r.go_init;
                    nxt.rdata[psc_pkg::EVT_ERROR_BIT] = r.deep;
                end
                default: nxt.rdata = '0;
            endcase
        end
        // Applied outputs: zero pulls low, one releases to pull-up
        nxt.pin = 3'h0;
        nxt.pin_oe = ~out_app;
        nxt.freq_o = freq_app;
        nxt.mhz = freq_mhz(freq_app);
    end

    // ---------------------------------------------
    // State register
    // ---------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
            // Complements start inverted so every pair agrees
            r.out_ctrl_inv <= psc_pkg::OUT_RST;
            r.osc_freq_sel_inv <= ~psc_pkg::FREQ_RST;
            r.err_lim_inv <= ~psc_pkg::LIM_RST;
            r.rfr_lim_inv <= ~psc_pkg::LIM_RST;
            r.fail_act_inv <= ~psc_pkg::FAIL_STAY;
            r.pin_oe <= 3'h7;
            // Applied code 0 decodes to 20 MHz
            r.mhz <= 7'h14;
        end else begin
            r <= nxt;
        end
    end

    // ---------------------------------------------
    // Outputs, each straight from the state register
    // ---------------------------------------------
    assign rdata_o = r.rdata;
    assign out_pin_o = r.pin;
    assign out_pin_oe_o = r.pin_oe;
    assign osc_freq_sel_o = r.freq_o;
    assign spread_enable_o = r.spread_enable;
    assign spread_mod_rate_o = r.spread_mod_rate;
    assign osc_mhz_o = r.mhz;
    assign sup_fail_o = r.fail;
    assign go_init_o = r.go_init;
    assign deep_failsafe_state_o = r.deep;
endmodule

// ### include/psc_pkg.sv
// Purpose: Shared constants for the protected safety control bank
// Assumes: 16-bit registers on a plain strobe port
// Notes: Offsets are register indices on the local port
package psc_pkg;
    localparam int AW = 3;
    localparam int DW = 16;
    // Register map
    localparam logic [2:0] ADDR_OUT_CTRL = 3'h0;
    localparam logic [2:0] ADDR_OUT_INV = 3'h1;
    localparam logic [2:0] ADDR_OSC = 3'h2;
    localparam logic [2:0] ADDR_OSC_INV = 3'h3;
    localparam logic [2:0] ADDR_SUP1 = 3'h4;
    localparam logic [2:0] ADDR_SUP1_INV = 3'h5;
    localparam logic [2:0] ADDR_SUP_EVT = 3'h6;
    // Field positions
    localparam int OUT_LSB = 0;
    localparam int MOD_RATE_BIT = 5;
    localparam int SPREAD_EN_BIT = 4;
    localparam int FREQ_LSB = 0;
    localparam int ERR_LIM_LSB = 14;
    localparam int RFR_LIM_LSB = 11;
    localparam int FAIL_LSB = 8;
    localparam int RFR_CNT_LSB = 4;
    localparam int ERR_CNT_LSB = 0;
    localparam int EVT_REFRESH_BIT = 0;
    localparam int EVT_ERROR_BIT = 1;
    // Reset values: all fields clear except complements, set so pairs match
    localparam logic [2:0] OUT_RST = 3'h7;
    localparam logic [3:0] FREQ_RST = 4'h0;
    localparam logic [1:0] LIM_RST = 2'h0;
    // Limits
    localparam logic [3:0] ERR_MAX_00 = 4'h8;
    localparam logic [3:0] ERR_MAX_01 = 4'h6;
    localparam logic [3:0] ERR_MAX_10 = 4'h4;
    localparam logic [3:0] ERR_MAX_11 = 4'h2;
    localparam logic [2:0] RFR_MAX_00 = 3'h6;
    localparam logic [2:0] RFR_MAX_01 = 3'h4;
    localparam logic [2:0] RFR_MAX_10 = 3'h2;
    localparam logic [2:0] RFR_MAX_11 = 3'h1;
    // Fail actions
    localparam logic [1:0] FAIL_STAY = 2'h0;
    localparam logic [1:0] FAIL_INIT = 2'h1;
    localparam logic [1:0] FAIL_DEEP = 2'h2;
    // Spread modulation rates in Hz
    localparam int MOD_SLOW_HZ = 23500;
    localparam int MOD_FAST_HZ = 94000;
endpackage

// ### core/psc_match.sv
// Purpose: Apply a protected field only while its copies agree
// Assumes: Complement copy lives in another register
// Notes: Holds the last agreed value otherwise
`timescale 1ns/1ps
module psc_match #(
    parameter int W = 2,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Field copies
    input wire logic [W-1:0] true_i,
    input wire logic [W-1:0] inv_i,
    // Applied value
    output logic [W-1:0] applied_o
);
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            applied_o <= RST;
        end else if (true_i == ~inv_i) begin
            applied_o <= true_i;
        end
    end
endmodule

// ### dv/psc_regs_props.sv
// Purpose: Port-level checks for the protected control bank
// Assumes: Bound to psc_regs, a single clock domain
// Notes: Shadows follow the oscillator pair as written on the bus
`timescale 1ns/1ps
module psc_regs_props (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Register port
    input wire logic [psc_pkg::AW-1:0] addr_i,
    input wire logic [psc_pkg::DW-1:0] wdata_i,
    input wire logic wr_i,
    // Events and outputs
    input wire logic refresh_bad_i,
    input wire logic [2:0] out_pin_o,
    input wire logic [3:0] osc_freq_sel_o,
    input wire logic [6:0] osc_mhz_o,
    input wire logic sup_fail_o,
    input wire logic go_init_o,
    input wire logic deep_failsafe_state_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic [3:0] f_r;
    logic [3:0] n_r;
    logic [2:0] since_bad_r;
    function automatic logic [6:0] mhz_of(input logic [3:0] c);
        if (c <= 4'h4) return 7'h14 + 7'(c);
        if (c >= 4'h9 && c <= 4'hB) return 7'h07 + 7'(c);
        return 7'h00;
    endfunction
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            f_r <= 4'h0;
            n_r <= 4'hF;
            since_bad_r <= 3'h7;
        end else begin
            if (wr_i && addr_i == psc_pkg::ADDR_OSC) f_r <= wdata_i[3:0];
            if (wr_i && addr_i == psc_pkg::ADDR_OSC_INV) n_r <= wdata_i[3:0];
            if (refresh_bad_i) since_bad_r <= 3'h0;
            else if (since_bad_r != 3'h7) since_bad_r <= since_bad_r + 3'h1;
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence osc_pair_s;
        (wr_i && addr_i == psc_pkg::ADDR_OSC) ##1
        (wr_i && addr_i == psc_pkg::ADDR_OSC_INV &&
         wdata_i[3:0] == ~$past(wdata_i[3:0]));
    endsequence
    osc_pair_a: assert property (osc_pair_s |->
        ##3 osc_freq_sel_o == $past(wdata_i[3:0], 4))
        else $error("oscillator code not applied after matching pair");
    freq_guard_a: assert property ($changed(osc_freq_sel_o) |->
        $past(f_r == ~n_r, 2) && osc_freq_sel_o == $past(f_r, 2))
        else $error("oscillator code changed without matching copies");
    freq_mhz_a: assert property (osc_mhz_o == mhz_of(osc_freq_sel_o))
        else $error("oscillator frequency does not match code");
    pin_low_a: assert property (out_pin_o == 3'h0)
        else $error("output pin drives a high level");
    fail_pulse_a: assert property (sup_fail_o |=> !sup_fail_o)
        else $error("failure pulse longer than one cycle");
    init_sticky_a: assert property (go_init_o |=> go_init_o)
        else $error("initialisation request dropped");
    deep_sticky_a: assert property (deep_failsafe_state_o |=>
        deep_failsafe_state_o)
        else $error("deep fail-safe state dropped");
    fail_cause_a: assert property (sup_fail_o |-> since_bad_r < 3'h4)
        else $error("failure without a recent bad refresh");
endmodule

// ### dv/psc_regs_tb_top.sv
// Purpose: Directed register tests for the protected control bank
// Assumes: Register port with read data one cycle after the strobe
// Notes: Expected values follow the field tables, not the design
`timescale 1ns/1ps
module psc_regs_tb_top;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [psc_pkg::AW-1:0] addr_i = 3'h0;
    logic [psc_pkg::DW-1:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic refresh_ok_i = 1'b0;
    logic refresh_bad_i = 1'b0;
    logic [psc_pkg::DW-1:0] rdata_o;
    logic [2:0] out_pin_o;
    logic [2:0] out_pin_oe_o;
    logic [3:0] osc_freq_sel_o;
    logic spread_enable_o;
    logic spread_mod_rate_o;
    logic [6:0] osc_mhz_o;
    logic sup_fail_o;
    logic go_init_o;
    logic deep_failsafe_state_o;
    int fail_cnt = 0;
    int fail_base = 0;
    int bad_count = 0;
    int n_tests = 0;
    psc_regs i_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .refresh_ok_i(refresh_ok_i),
        .refresh_bad_i(refresh_bad_i), .out_pin_o(out_pin_o),
        .out_pin_oe_o(out_pin_oe_o), .osc_freq_sel_o(osc_freq_sel_o),
        .spread_enable_o(spread_enable_o),
        .spread_mod_rate_o(spread_mod_rate_o), .osc_mhz_o(osc_mhz_o),
        .sup_fail_o(sup_fail_o), .go_init_o(go_init_o),
        .deep_failsafe_state_o(deep_failsafe_state_o));
    // ------------------------------------------------------------
    // Clock, pulse catcher and tasks
    // ------------------------------------------------------------
    initial forever #12.5 sys_clk_i = ~sys_clk_i;
    // Failure is a one-cycle pulse, so count it for later checks
    always @(posedge sys_clk_i) begin
        if (sup_fail_o === 1'b1) fail_cnt <= fail_cnt + 1;
    end
    function automatic logic [15:0] exp_mhz(input logic [3:0] c);
        if (c <= 4'h4) return 16'h0014 + 16'(c);
        if (c >= 4'h9 && c <= 4'hB) return 16'h0007 + 16'(c);
        return 16'h0000;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
    endtask
    task automatic idle(input int n);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic rd(input logic [2:0] a, input logic [15:0] exp);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask
    task automatic pulse(input logic bad);
        @(posedge sys_clk_i);
        refresh_ok_i <= !bad;
        refresh_bad_i <= bad;
        @(posedge sys_clk_i);
        refresh_ok_i <= 1'b0;
        refresh_bad_i <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic do_reset();
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        #1;
        check(16'(out_pin_oe_o), 16'h0007);
        check(16'(osc_mhz_o), 16'h0014);
        check(16'({go_init_o, deep_failsafe_state_o}), 16'h0000);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        for (int c = 0; c < 16; c++) begin
            wr(psc_pkg::ADDR_OSC, 16'(c[3:0]));
            wr(psc_pkg::ADDR_OSC_INV, 16'(~c[3:0]));
            idle(2);
            check(16'(osc_freq_sel_o), 16'(c[3:0]));
            check(16'(osc_mhz_o), exp_mhz(c[3:0]));
        end
        wr(psc_pkg::ADDR_OSC, 16'h0002);
        wr(psc_pkg::ADDR_OSC_INV, 16'h0000);
        idle(2);
        check(16'(osc_freq_sel_o), 16'h000F);
        rd(psc_pkg::ADDR_OSC_INV, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(psc_pkg::ADDR_OSC, 16'(k << 4));
            idle(2);
            check(16'({spread_enable_o, spread_mod_rate_o}),
                16'({k[0], k[1]}));
        end
        wr(psc_pkg::ADDR_OUT_CTRL, 16'h0005);
        wr(psc_pkg::ADDR_OUT_INV, 16'h0002);
        idle(2);
        check(16'(out_pin_oe_o), 16'h0002);
        check(16'(out_pin_o), 16'h0000);
        rd(psc_pkg::ADDR_OUT_INV, 16'h0002);
        wr(psc_pkg::ADDR_OUT_INV, 16'h0007);
        idle(2);
        check(16'(out_pin_oe_o), 16'h0002);
        // Unmapped index: write dropped, read returns zero
        wr(3'h7, 16'hFFFF);
        rd(3'h7, 16'h0000);
        wr(psc_pkg::ADDR_SUP1, 16'h0100);
        wr(psc_pkg::ADDR_SUP1_INV, 16'hDA00);
        idle(2);
        repeat (3) pulse(1'b0);
        rd(psc_pkg::ADDR_SUP1, 16'h0130);
        pulse(1'b1);
        rd(psc_pkg::ADDR_SUP1, 16'h0102);
        fail_base = fail_cnt;
        repeat (3) pulse(1'b1);
        rd(psc_pkg::ADDR_SUP1, 16'h0100);
        check(16'(fail_cnt - fail_base), 16'h0001);
        rd(psc_pkg::ADDR_SUP_EVT, 16'h0001);
        wr(psc_pkg::ADDR_SUP1, 16'hDA00);
        wr(psc_pkg::ADDR_SUP1_INV, 16'h0100);
        idle(2);
        pulse(1'b0);
        rd(psc_pkg::ADDR_SUP1, 16'hDA00);
        pulse(1'b1);
        rd(psc_pkg::ADDR_SUP_EVT, 16'h0003);
        check(16'(fail_cnt - fail_base), 16'h0002);
        do_reset();
        rd(psc_pkg::ADDR_SUP1, 16'h0000);
        rd(psc_pkg::ADDR_OSC, 16'h0000);
        give_verdict();
    end
    // Whole run needs well under 1000 cycles
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end
endmodule
bind psc_regs psc_regs_props i_chk (.sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .refresh_bad_i(refresh_bad_i), .out_pin_o(out_pin_o),
    .osc_freq_sel_o(osc_freq_sel_o), .osc_mhz_o(osc_mhz_o),
    .sup_fail_o(sup_fail_o), .go_init_o(go_init_o),
    .deep_failsafe_state_o(deep_failsafe_state_o));
